// >>> ashb_pkg.sv
package ashb_pkg;
    // clock rates and bus timing
    localparam int unsigned SYS_CLK_KHZ        = 200000;
    localparam int unsigned LINK_CLK_PERIOD_PS = 48000;
    localparam int unsigned AUX_SCL_KHZ        = 400;
    localparam int unsigned AUX_QTR_PS         = 1000000000 / AUX_SCL_KHZ / 4;
    // least quarter bit time, rounded up so the bus never runs fast
    localparam int unsigned AUX_QTR_CYC        =
        (AUX_QTR_PS + LINK_CLK_PERIOD_PS - 1) / LINK_CLK_PERIOD_PS;
    localparam int unsigned SYNC_CLK_KHZ       = 1024;
    localparam int unsigned SYNC_HALF_CYC      = SYS_CLK_KHZ / (2 * SYNC_CLK_KHZ);
    localparam int unsigned SAMPLE_HZ          = 1000;
    localparam int unsigned SAMPLE_CYC         = SYS_CLK_KHZ / SAMPLE_HZ * 1000;

    // primary slave address, upper six bits
    localparam logic [5:0] SLV_ADDR_HI  = 6'h34;
    localparam logic [2:0] CLK_SRC_INT  = 3'h0;
    localparam logic [3:0] ACK_BIT      = 4'h8;

    // burst sequence steps
    localparam logic [3:0] SEQ_START    = 4'h0;
    localparam logic [3:0] SEQ_DEV_W    = 4'h1;
    localparam logic [3:0] SEQ_REG      = 4'h2;
    localparam logic [3:0] SEQ_RSTART   = 4'h3;
    localparam logic [3:0] SEQ_DEV_R    = 4'h4;
    localparam logic [3:0] SEQ_RD_FIRST = 4'h5;
    localparam logic [3:0] SEQ_RD_LAST  = 4'hA;
    localparam logic [3:0] SEQ_STOP     = 4'hB;

    typedef enum logic [1:0] {SYM_START, SYM_WR, SYM_RD, SYM_STOP} ashb_sym_t;
    typedef enum logic {LK_IDLE, LK_RUN} ashb_link_st_t;
    typedef enum logic [2:0] {
        SL_IDLE, SL_ADDR, SL_ACK_A, SL_WRITE, SL_ACK_W, SL_READ, SL_ACK_R
    } ashb_slv_st_t;

    typedef struct packed {
        logic [6:0] dev_addr;
        logic [7:0] reg_addr;
    } ashb_cfg_t;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } ashb_accel_t;
endpackage

// >>> ashb_top.sv
`timescale 1ns/1ps
module ashb_top #(
    parameter int unsigned SAMPLE_CYCLES = ashb_pkg::SAMPLE_CYC
) (
    // clocks and reset
    input  wire logic               i_clock,
    input  wire logic               i_aux_clock,
    input  wire logic               i_sys_rst,
    // primary bus pins
    input  wire logic               i_scl,
    output logic                    o_scl,
    output logic                    o_scl_oe_n,
    input  wire logic               i_sda,
    output logic                    o_sda,
    output logic                    o_sda_oe_n,
    input  wire logic               i_address_select_pin,
    // aux bus pins
    output logic                    o_aux_clock_line,
    output logic                    o_aux_clock_line_oe_n,
    input  wire logic               i_aux_data_line,
    output logic                    o_aux_data_line,
    output logic                    o_aux_data_line_oe_n,
    // sync clock
    input  wire logic               i_sync_clock_en,
    output logic                    o_sync_clock_output,
    // control
    input  wire logic               i_mode_pass,
    input  wire logic               i_auto_en,
    input  wire logic               i_burst_start,
    input  wire ashb_pkg::ashb_cfg_t i_burst_cfg,
    input  wire logic               i_clk_src_wr,
    input  wire logic [2:0]         i_clk_src_sel,
    // status and results
    output logic                    o_mode_pass,
    output logic                    o_busy,
    output ashb_pkg::ashb_accel_t   o_accel,
    output logic                    o_accel_valid,
    output logic                    o_aux_nack,
    output logic [2:0]              o_clock_source,
    // register port toward the device core
    output logic [7:0]              o_reg_addr,
    output logic [7:0]              o_reg_wdata,
    output logic                    o_reg_we,
    input  wire logic [7:0]         i_reg_rdata
);

    // sequence step decode, used for the current and the next step
    function automatic ashb_pkg::ashb_sym_t ashb_sym(input logic [3:0] s);
        if (s == ashb_pkg::SEQ_START || s == ashb_pkg::SEQ_RSTART) begin
            return ashb_pkg::SYM_START;
        end else if (s == ashb_pkg::SEQ_STOP) begin
            return ashb_pkg::SYM_STOP;
        end else if (s >= ashb_pkg::SEQ_RD_FIRST) begin
            return ashb_pkg::SYM_RD;
        end
        return ashb_pkg::SYM_WR;
    endfunction

    // ---------------- system domain inputs ----------------
    logic [2:0] p_scl_q;
    logic [2:0] p_sda_q;
    logic [1:0] aux_sda_q;
    logic [1:0] adsel_q;
    logic [1:0] ack_s_q;
    logic       ack_s3_q;

    // two flops before use, third stage only for edges
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            p_scl_q   <= 3'h7;
            p_sda_q   <= 3'h7;
            aux_sda_q <= 2'h3;
            adsel_q   <= 2'h0;
        end else begin
            p_scl_q   <= {p_scl_q[1:0], i_scl};
            p_sda_q   <= {p_sda_q[1:0], i_sda};
            aux_sda_q <= {aux_sda_q[0], i_aux_data_line};
            adsel_q   <= {adsel_q[0], i_address_select_pin};
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise  = p_scl_q[1] & ~p_scl_q[2];
    assign scl_fall  = ~p_scl_q[1] & p_scl_q[2];
    assign bus_start = p_scl_q[1] & p_scl_q[2] & ~p_sda_q[1] & p_sda_q[2];
    assign bus_stop  = p_scl_q[1] & p_scl_q[2] & p_sda_q[1] & ~p_sda_q[2];

    // ---------------- mode, requests, crossing ----------------
    logic                  mode_q;
    logic                  pend_q;
    logic                  req_t_q;
    logic                  issue;
    logic [31:0]           tmr_q;
    ashb_pkg::ashb_cfg_t   cfg_q;
    logic                  link_done;
    logic                  lk_scl_q;
    logic                  lk_low_q;
    logic                  lk_ack_t_q;
    logic                  lk_err_q;
    logic [47:0]           lk_res_q;

    assign o_busy    = req_t_q ^ ack_s_q[1];
    assign issue     = pend_q & ~o_busy & ~mode_q & ~i_mode_pass;
    assign link_done = ack_s_q[1] ^ ack_s3_q;

    // mode follows its input only between bursts
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode_q <= 1'b0;
        end else if (!o_busy && !issue) begin
            mode_q <= i_mode_pass;
        end
    end

    // periodic sample timer so bursts run without the host
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tmr_q <= 32'h0;
        end else if (!i_auto_en || tmr_q == 32'(SAMPLE_CYCLES - 1)) begin
            tmr_q <= 32'h0;
        end else begin
            tmr_q <= tmr_q + 32'h1;
        end
    end

    // pending burst; a new trigger wins over the clear
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= (pend_q & ~issue) | i_burst_start
                    | (i_auto_en & tmr_q == 32'(SAMPLE_CYCLES - 1));
        end
    end

    // request toggle; config is held steady until the ack returns
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            req_t_q <= 1'b0;
            cfg_q   <= '0;
        end else if (issue) begin
            req_t_q <= ~req_t_q;
            cfg_q   <= i_burst_cfg;
        end
    end

    // ack toggle back from the link side
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ack_s_q  <= 2'h0;
            ack_s3_q <= 1'b0;
        end else begin
            ack_s_q  <= {ack_s_q[0], lk_ack_t_q};
            ack_s3_q <= ack_s_q[1];
        end
    end

    // results are stable in the link flops once the ack is seen
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_accel       <= '0;
            o_accel_valid <= 1'b0;
            o_aux_nack    <= 1'b0;
        end else begin
            o_accel_valid <= link_done & ~lk_err_q;
            o_aux_nack    <= link_done & lk_err_q;
            if (link_done && !lk_err_q) begin
                o_accel <= lk_res_q;
            end
        end
    end
    assign o_mode_pass = mode_q;

    // clock source starts on the internal oscillator
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_clock_source <= ashb_pkg::CLK_SRC_INT;
        end else if (i_clk_src_wr) begin
            o_clock_source <= i_clk_src_sel;
        end
    end

    // sync clock divider, slightly above 1.024MHz after rounding
    logic [7:0] div_q;
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            div_q               <= 8'h0;
            o_sync_clock_output <= 1'b0;
        end else if (!i_sync_clock_en) begin
            div_q               <= 8'h0;
            o_sync_clock_output <= 1'b0;
        end else if (div_q == 8'(ashb_pkg::SYNC_HALF_CYC - 1)) begin
            div_q               <= 8'h0;
            o_sync_clock_output <= ~o_sync_clock_output;
        end else begin
            div_q <= div_q + 8'h1;
        end
    end

    // ---------------- primary bus slave ----------------
    ashb_pkg::ashb_slv_st_t sst_q;
    logic [3:0] scnt_q;
    logic [7:0] sshr_q;
    logic [7:0] tx_q;
    logic       slow_q;
    logic       srd_q;
    logic       first_q;
    logic       macked_q;

    // reacts to host framing only; nothing here can start a transfer
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sst_q <= ashb_pkg::SL_IDLE;
            scnt_q <= 4'h0;
            sshr_q <= 8'h0;
            tx_q <= 8'h0;
            slow_q <= 1'b0;
            srd_q <= 1'b0;
            first_q <= 1'b0;
            macked_q <= 1'b0;
            o_reg_addr <= 8'h0;
            o_reg_wdata <= 8'h0;
            o_reg_we <= 1'b0;
        end else begin
            o_reg_we <= 1'b0;
            if (o_reg_we) begin
                o_reg_addr <= o_reg_addr + 8'h1;
            end
            if (bus_start) begin
                sst_q  <= ashb_pkg::SL_ADDR;
                scnt_q <= 4'h0;
                slow_q <= 1'b0;
            end else if (bus_stop) begin
                sst_q  <= ashb_pkg::SL_IDLE;
                slow_q <= 1'b0;
            end else if (scl_rise) begin
                unique case (sst_q)
                    ashb_pkg::SL_ADDR, ashb_pkg::SL_WRITE: begin
                        sshr_q <= {sshr_q[6:0], p_sda_q[1]};
                        scnt_q <= scnt_q + 4'h1;
                    end
                    ashb_pkg::SL_READ: scnt_q <= scnt_q + 4'h1;
                    ashb_pkg::SL_ACK_R: macked_q <= ~p_sda_q[1];
                    default: ;
                endcase
            end else if (scl_fall) begin
                unique case (sst_q)
                    ashb_pkg::SL_ADDR: begin
                        if (scnt_q == ashb_pkg::ACK_BIT) begin
                            if (sshr_q[7:1] == {ashb_pkg::SLV_ADDR_HI, adsel_q[1]}) begin
                                slow_q <= 1'b1;
                                srd_q  <= sshr_q[0];
                                sst_q  <= ashb_pkg::SL_ACK_A;
                            end else begin
                                sst_q <= ashb_pkg::SL_IDLE;
                            end
                        end
                    end
                    ashb_pkg::SL_ACK_A, ashb_pkg::SL_ACK_R: begin
                        scnt_q <= 4'h0;
                        if ((sst_q == ashb_pkg::SL_ACK_A && srd_q) ||
                            (sst_q == ashb_pkg::SL_ACK_R && macked_q)) begin
                            tx_q       <= i_reg_rdata;
                            slow_q     <= ~i_reg_rdata[7];
                            o_reg_addr <= o_reg_addr + 8'h1;
                            sst_q      <= ashb_pkg::SL_READ;
                        end else if (sst_q == ashb_pkg::SL_ACK_A) begin
                            slow_q  <= 1'b0;
                            first_q <= 1'b1;
                            sst_q   <= ashb_pkg::SL_WRITE;
                        end else begin
                            slow_q <= 1'b0;
                            sst_q  <= ashb_pkg::SL_IDLE;
                        end
                    end
                    ashb_pkg::SL_WRITE: begin
                        if (scnt_q == ashb_pkg::ACK_BIT) begin
                            if (first_q) begin
                                o_reg_addr <= sshr_q;
                            end else begin
                                o_reg_we    <= 1'b1;
                                o_reg_wdata <= sshr_q;
                            end
                            first_q <= 1'b0;
                            slow_q  <= 1'b1;
                            sst_q   <= ashb_pkg::SL_ACK_W;
                        end
                    end
                    ashb_pkg::SL_ACK_W: begin
                        slow_q <= 1'b0;
                        scnt_q <= 4'h0;
                        sst_q  <= ashb_pkg::SL_WRITE;
                    end
                    ashb_pkg::SL_READ: begin
                        if (scnt_q == ashb_pkg::ACK_BIT) begin
                            slow_q <= 1'b0;
                            sst_q  <= ashb_pkg::SL_ACK_R;
                        end else begin
                            tx_q   <= {tx_q[6:0], 1'b0};
                            slow_q <= ~tx_q[6];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ---------------- pass-through join ----------------
    logic       host_drv;
    logic [2:0] drv_hist_q;
    logic       aux_owns_q;
    assign host_drv = mode_q & ~p_sda_q[1] & ~aux_owns_q;

    // aux side owns the line only if we have not echoed a low lately,
    // otherwise our own echo would look like the accelerometer pulling
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            drv_hist_q <= 3'h0;
            aux_owns_q <= 1'b0;
        end else begin
            drv_hist_q <= {drv_hist_q[1:0], host_drv};
            if (!mode_q || aux_sda_q[1]) begin
                aux_owns_q <= 1'b0;
            end else if (drv_hist_q == 3'h0 && !host_drv) begin
                aux_owns_q <= 1'b1;
            end
        end
    end

    // pin drivers; the primary clock is never driven
    assign o_scl                 = 1'b0;
    assign o_scl_oe_n            = 1'b1;
    assign o_sda                 = 1'b0;
    assign o_sda_oe_n            = ~(slow_q | (mode_q & aux_owns_q));
    assign o_aux_clock_line      = mode_q ? p_scl_q[1] : lk_scl_q;
    assign o_aux_clock_line_oe_n = 1'b0;
    assign o_aux_data_line       = 1'b0;
    assign o_aux_data_line_oe_n  = mode_q ? ~host_drv : ~lk_low_q;

    // ---------------- link domain: aux bus master ----------------
    logic [1:0]            lrst_q;
    logic                  lrst;
    logic [2:0]            lreq_q;
    logic [1:0]            lsda_q;
    ashb_pkg::ashb_link_st_t lst_q;
    logic [3:0]            seq_q;
    logic [1:0]            ph_q;
    logic [3:0]            bit_q;
    logic [4:0]            qcnt_q;
    assign lrst = lrst_q[1];

    // local reset release on the link clock
    always_ff @(posedge i_aux_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lrst_q <= 2'h3;
        end else begin
            lrst_q <= {lrst_q[0], 1'b0};
        end
    end

    // request toggle and data pin synchronisers
    always_ff @(posedge i_aux_clock or posedge lrst) begin
        if (lrst) begin
            lreq_q <= 3'h0;
            lsda_q <= 2'h3;
        end else begin
            lreq_q <= {lreq_q[1:0], req_t_q};
            lsda_q <= {lsda_q[0], i_aux_data_line};
        end
    end

    logic                 tick;
    ashb_pkg::ashb_sym_t  kind;
    ashb_pkg::ashb_sym_t  nkind;
    logic [3:0]           nseq;
    logic [1:0]           nph;
    logic [3:0]           nbit;
    logic                 nack;
    logic                 fin;
    logic [7:0]           wbyte;
    logic                 nscl;
    logic                 nlow;
    assign tick = qcnt_q == 5'(ashb_pkg::AUX_QTR_CYC - 1);
    assign kind = ashb_sym(seq_q);

    // next step and the pin levels of the next quarter
    always_comb begin
        nseq  = seq_q;
        nph   = ph_q + 2'h1;
        nbit  = bit_q;
        nack  = 1'b0;
        fin   = 1'b0;
        if (ph_q == 2'h3) begin
            if (kind == ashb_pkg::SYM_WR && bit_q == ashb_pkg::ACK_BIT && lsda_q[1]) begin
                nack = 1'b1;
                nseq = ashb_pkg::SEQ_STOP;
                nbit = 4'h0;
            end else if (kind != ashb_pkg::SYM_START && kind != ashb_pkg::SYM_STOP &&
                         bit_q != ashb_pkg::ACK_BIT) begin
                nbit = bit_q + 4'h1;
            end else if (kind == ashb_pkg::SYM_STOP) begin
                fin = 1'b1;
            end else begin
                nseq = seq_q + 4'h1;
                nbit = 4'h0;
            end
        end
        nkind = ashb_sym(nseq);
        if (nseq == ashb_pkg::SEQ_REG) begin
            wbyte = cfg_q.reg_addr;
        end else begin
            wbyte = {cfg_q.dev_addr, nseq == ashb_pkg::SEQ_DEV_R};
        end
        nscl = nph[1];
        nlow = 1'b0;
        unique case (nkind)
            ashb_pkg::SYM_START: begin
                nscl = nph[0] ^ nph[1];
                nlow = nph[1];
            end
            ashb_pkg::SYM_STOP: begin
                nscl = nph != 2'h0;
                nlow = ~nph[1];
            end
            ashb_pkg::SYM_WR: nlow = ~nbit[3] & ~wbyte[3'h7 - nbit[2:0]];
            // last byte is left unacknowledged before stop
            ashb_pkg::SYM_RD: nlow = nbit[3] & (nseq != ashb_pkg::SEQ_RD_LAST);
        endcase
    end

    // burst engine; result and error stay put until the next request
    always_ff @(posedge i_aux_clock or posedge lrst) begin
        if (lrst) begin
            lst_q      <= ashb_pkg::LK_IDLE;
            seq_q      <= ashb_pkg::SEQ_START;
            ph_q       <= 2'h0;
            bit_q      <= 4'h0;
            qcnt_q     <= 5'h0;
            lk_scl_q   <= 1'b1;
            lk_low_q   <= 1'b0;
            lk_ack_t_q <= 1'b0;
            lk_err_q   <= 1'b0;
            lk_res_q   <= 48'h0;
        end else if (lst_q == ashb_pkg::LK_IDLE) begin
            qcnt_q <= 5'h0;
            if (lreq_q[2] ^ lreq_q[1]) begin
                lst_q    <= ashb_pkg::LK_RUN;
                seq_q    <= ashb_pkg::SEQ_START;
                ph_q     <= 2'h0;
                bit_q    <= 4'h0;
                lk_err_q <= 1'b0;
                lk_scl_q <= 1'b0;
                lk_low_q <= 1'b0;
            end
        end else begin
            qcnt_q <= tick ? 5'h0 : qcnt_q + 5'h1;
            if (tick) begin
                if (ph_q == 2'h3 && kind == ashb_pkg::SYM_RD && !bit_q[3]) begin
                    lk_res_q <= {lk_res_q[46:0], lsda_q[1]};
                end
                if (nack) begin
                    lk_err_q <= 1'b1;
                end
                if (fin) begin
                    lst_q      <= ashb_pkg::LK_IDLE;
                    lk_ack_t_q <= ~lk_ack_t_q;
                    lk_scl_q   <= 1'b1;
                    lk_low_q   <= 1'b0;
                end else begin
                    seq_q    <= nseq;
                    ph_q     <= nph;
                    bit_q    <= nbit;
                    lk_scl_q <= nscl;
                    lk_low_q <= nlow;
                end
            end
        end
    end

endmodule

// >>> ashb_top_asserts.sv
`timescale 1ns/1ps
module ashb_checker (
    input wire logic                  i_clock, i_sys_rst, i_scl, i_sync_clock_en,
    input wire logic                  o_scl_oe_n, o_aux_clock_line, o_aux_clock_line_oe_n,
    input wire logic                  o_aux_data_line, o_sync_clock_output, o_mode_pass,
    input wire logic                  o_busy, o_accel_valid, i_clk_src_wr,
    input wire logic [2:0]            i_clk_src_sel, o_clock_source,
    input wire ashb_pkg::ashb_accel_t o_accel
);
    logic       last_q;
    logic [7:0] cnt_q;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // cycles since the sync output moved; 0 until one whole half period is seen
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            last_q <= 1'b0;
            cnt_q  <= 8'h00;
        end else begin
            last_q <= o_sync_clock_output;
            cnt_q  <= !i_sync_clock_en ? 8'h00 : (o_sync_clock_output != last_q) ? 8'h01
                      : cnt_q + {7'h00, cnt_q != 8'h00};
        end
    end
    AST_SCL_NEVER: assert property (o_scl_oe_n)
        else $error("primary clock driven");
    AST_AUX_CLOCK_LINE_PP: assert property (!o_aux_clock_line_oe_n)
        else $error("aux clock not driven");
    AST_AUX_DATA_LINE_OD: assert property (!o_aux_data_line)
        else $error("aux data driven high");
    AST_PASS_CL: assert property ((o_mode_pass && $stable(i_scl))[*6] |->
        o_aux_clock_line == i_scl) else $error("aux clock not joined");
    AST_MODE_HOLD: assert property (o_busy |=> $stable(o_mode_pass))
        else $error("mode moved in a burst");
    AST_PASS_IDLE: assert property (o_mode_pass |-> !o_busy)
        else $error("master busy in pass mode");
    AST_ACCEL_UPD: assert property ($changed(o_accel) |-> o_accel_valid)
        else $error("accel moved without valid");
    AST_CLK_SRC: assert property (i_clk_src_wr |=> o_clock_source == $past(i_clk_src_sel))
        else $error("clock source not written");
    AST_SYNC_HALF: assert property (o_sync_clock_output != last_q && cnt_q != 8'h00 |->
        cnt_q == ashb_pkg::SYNC_HALF_CYC) else $error("sync half period wrong");
    COV_BURST: cover property (o_accel_valid);
    COV_PASS: cover property (o_mode_pass && !i_scl);
    COV_SYNC: cover property ($rose(o_sync_clock_output));
endmodule
bind ashb_top ashb_checker u_ashb_checker (.*);

// >>> ashb_accel_model.sv
`timescale 1ns/1ps
module ashb_accel_model (
    input  wire logic i_scl,
    input  wire logic i_sda,
    input  wire logic i_nack_en,
    output logic      o_release
);
    logic [3:0] bit_q;
    logic [2:0] idx_q;
    logic       rd_q;
    logic       adr_q;
    logic [7:0] byte_q;
    initial o_release = 1'b1;
    // start restarts the byte count; stop lets the data line go
    always @(negedge i_sda) if (i_scl) begin
        bit_q = 4'hF;
        adr_q = 1'b1;
        rd_q  = 1'b0;
        idx_q = 3'h0;
    end
    always @(posedge i_sda) if (i_scl) o_release = 1'b1;
    // the read bit picks direction; a host nack ends the read
    always @(posedge i_scl) begin
        if (adr_q && bit_q == 4'h7) rd_q = i_sda;
        if (!adr_q && rd_q && bit_q == 4'h8 && i_sda) rd_q = 1'b0;
    end
    // data moves only while the clock is low, as a real slave must
    always @(negedge i_scl) begin
        if (bit_q == 4'h8) begin
            bit_q = 4'h0;
            adr_q = 1'b0;
        end else begin
            bit_q = bit_q + 4'h1;
        end
        byte_q = 8'hA0 + {5'h00, idx_q};
        if (bit_q == 4'h8) o_release = (rd_q && !adr_q) || (adr_q && i_nack_en);
        else o_release = !(rd_q && !adr_q) || byte_q[3'h7 - bit_q[2:0]];
        if (bit_q == 4'h7 && rd_q && !adr_q) idx_q = idx_q + 3'h1;
    end
endmodule

// >>> tb_aux_sensor_bus_hub.sv
`timescale 1ns/1ps
module tb_aux_sensor_bus_hub;
    logic i_clock = 1'b0, i_aux_clock = 1'b0, i_sys_rst = 1'b1, i_scl = 1'b1, i_sda = 1'b1;
    logic i_address_select_pin = 1'b1, i_mode_pass = 1'b0, i_burst_start = 1'b0;
    logic i_clk_src_wr = 1'b0, nack_en = 1'b0, o_sda_oe_n, o_aux_clock_line, mdl_release;
    logic o_aux_data_line_oe_n, o_mode_pass, o_busy, o_accel_valid, o_aux_nack;
    logic [2:0] i_clk_src_sel = 3'h0, o_clock_source;
    ashb_pkg::ashb_cfg_t   i_burst_cfg = '{dev_addr: 7'h1D, reg_addr: 8'h32};
    ashb_pkg::ashb_accel_t o_accel;
    wire aux_sda = o_aux_data_line_oe_n & mdl_release; // pull-up on aux data
    int err_total = 0, check_count = 0;
    ashb_top #(.SAMPLE_CYCLES(2000)) u_ashb_top (.i_clock(i_clock), .i_aux_clock(i_aux_clock),
        .i_sys_rst(i_sys_rst), .i_scl(i_scl), .o_scl(), .o_scl_oe_n(), .i_sda(i_sda), .o_sda(),
        .o_sda_oe_n(o_sda_oe_n), .i_address_select_pin(i_address_select_pin),
        .o_aux_clock_line(o_aux_clock_line), .o_aux_clock_line_oe_n(), .i_aux_data_line(aux_sda),
        .o_aux_data_line(), .o_aux_data_line_oe_n(o_aux_data_line_oe_n), .i_sync_clock_en(1'b1),
        .o_sync_clock_output(), .i_mode_pass(i_mode_pass), .i_auto_en(1'b0),
        .i_burst_start(i_burst_start), .i_burst_cfg(i_burst_cfg), .i_clk_src_wr(i_clk_src_wr),
        .i_clk_src_sel(i_clk_src_sel), .o_mode_pass(o_mode_pass), .o_busy(o_busy),
        .o_accel(o_accel), .o_accel_valid(o_accel_valid), .o_aux_nack(o_aux_nack),
        .o_clock_source(o_clock_source), .o_reg_addr(), .o_reg_wdata(), .o_reg_we(),
        .i_reg_rdata(8'h00));
    ashb_accel_model u_ashb_accel_model (.i_scl(o_aux_clock_line), .i_sda(aux_sda),
        .i_nack_en(nack_en), .o_release(mdl_release));
    initial forever #2.5 i_clock = ~i_clock;
    initial begin #7; forever #24 i_aux_clock = ~i_aux_clock; end
    task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
        check_count++;
        if (got !== exp) begin err_total++; $display("ERROR %s exp %0h got %0h", nm, exp, got); end
    endtask
    task automatic tick(input int n); repeat (n) @(posedge i_clock); endtask
    // one primary bit, data set while the clock is low
    task automatic pbit(input logic b);
        i_sda <= b; tick(30); i_scl <= 1'b1; tick(30); i_scl <= 1'b0; tick(30);
    endtask
    // host addresses the slave; only its own address earns an ack
    task automatic t_addr(input logic [6:0] a);
        logic ack;
        ack = (a === {ashb_pkg::SLV_ADDR_HI, i_address_select_pin});
        i_sda <= 1'b0; tick(30); i_scl <= 1'b0; tick(30);
        for (int i = 6; i >= 0; i--) pbit(a[i]);
        pbit(1'b0);
        i_sda <= 1'b1; tick(30); i_scl <= 1'b1; tick(15);
        #1 chk("addr_ack", 48'(ack), 48'(!o_sda_oe_n));
        tick(15); i_scl <= 1'b0; tick(30); i_sda <= 1'b0; tick(30);
        i_scl <= 1'b1; tick(30); i_sda <= 1'b1; tick(60);
    endtask
    // one burst; a refused address must end it and leave the data alone
    task automatic t_burst(input logic nk);
        int n;
        tick(1); nack_en <= nk; i_burst_start <= 1'b1; tick(1); i_burst_start <= 1'b0; n = 0;
        tick(2); i_mode_pass <= nk; tick(5); // a pass request lands mid burst when nk is set
        #1 chk("mode_hold", 48'h0, 48'(o_mode_pass));
        do begin tick(1); #1 n++; end
        while (o_accel_valid !== 1'b1 && o_aux_nack !== 1'b1 && n < 60000);
        chk("accel_valid", 48'(!nk), 48'(o_accel_valid));
        chk("aux_nack", 48'(nk), 48'(o_aux_nack));
        chk("accel", 48'hA0A1A2A3A4A5, o_accel);
        tick(50);
        #1 chk("busy", 48'h0, 48'(o_busy));
    endtask
    task automatic t_clksrc;
        #1 chk("clk_src_rst", 48'(ashb_pkg::CLK_SRC_INT), 48'(o_clock_source));
        tick(1); i_clk_src_sel <= 3'h5; i_clk_src_wr <= 1'b1;
        tick(1); i_clk_src_wr <= 1'b0; tick(1);
        #1 chk("clk_src", 48'h5, 48'(o_clock_source));
    endtask
    // pass mode joins the clocks and holds off bursts
    task automatic t_pass;
        tick(1); i_mode_pass <= 1'b1; tick(3);
        #1 chk("mode_pass", 48'h1, 48'(o_mode_pass));
        tick(1); i_scl <= 1'b0; tick(8);
        #1 chk("aux_clock_line_lo", 48'h0, 48'(o_aux_clock_line));
        tick(1); i_scl <= 1'b1; i_burst_start <= 1'b1; tick(1); i_burst_start <= 1'b0; tick(8);
        #1 chk("aux_clock_line_hi", 48'h1, 48'(o_aux_clock_line));
        chk("busy_pass", 48'h0, 48'(o_busy));
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        tick(20); i_sys_rst <= 1'b0; tick(5);
        t_clksrc();
        t_addr(7'h69);
        t_addr(7'h68);
        tick(1); i_address_select_pin <= 1'b0; tick(5);
        t_addr(7'h68);
        t_burst(1'b0);
        t_burst(1'b1);
        t_pass();
        t_addr(7'h68);
        conclude();
    end
    // watchdog sized for two bursts plus the primary traffic
    initial begin #450000; err_total++; conclude(); end
endmodule
